// ===== hdl/global_io_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the global I/O control registers.
 * Assumes a 32-bit AHB-Lite slave where each register takes one aligned word.
 */
`ifndef GLOBAL_IO_PARAMS_SVH
`define GLOBAL_IO_PARAMS_SVH

// Printed offsets are register indices; byte address is four times the index
`define CLKCTL_INDEX 12'h103
`define IBACTL_INDEX 12'h104
`define DRIVE_INDEX 12'h10d

// Output clock control fields
`define CLKCTL_FREQ_BIT 0
`define CLKCTL_EN_BIT 1
`define CLKCTL_RW_MASK 8'h1f
`define CLKCTL_RESET 8'h02

// In-band management control fields
`define IBA_EN_BIT 31
`define IBA_MATCH_BIT 30
`define IBA_RST_BIT 29
`define IBA_PRIO_HI 23
`define IBA_PRIO_LO 22
`define IBA_PORT_HI 18
`define IBA_PORT_LO 16
`define IBA_TYPE_HI 15
`define IBA_TYPE_LO 0
`define IBA_RW_MASK 32'hc0c7ffff
`define IBA_RESET 32'h004540fe

// Drive strength fields
`define DRV_HIGH_HI 6
`define DRV_HIGH_LO 4
`define DRV_LOW_HI 2
`define DRV_LOW_LO 0
`define DRIVE_RESET 8'h62

// Length of the in-band engine reset pulse in core cycles
`define IBA_RST_CYCLES 1

`endif

// ===== hdl/global_io_pkg.sv
/*
 * Types shared by the global I/O control register block.
 * Assumes the params header supplies the numbers.
 */
package global_io_pkg;
    // Data phase tracking of the bus slave
    typedef enum logic [2:0] {
        phase_idle_type_s = 3'b001,
        phase_write_type_s = 3'b010,
        phase_read_type_s = 3'b100
    } phase_type;

    typedef logic [31:0] word_type;
    typedef logic [2:0] code3_type;
endpackage : global_io_pkg

// ===== hdl/global_io_control_regs.sv
/*
 * Global I/O control registers: reference clock output control, in-band management control
 * word and pad drive strength codes, reached over AHB-Lite with zero wait states.
 *
 * Word map (byte address is four times the word index):
 *   0x103 output clock control, low byte: rate bit 0, pin enable bit 1, spare 4:2, zero 7:5
 *   0x104 in-band control: enable 31, address match 30, engine reset 29 (reads zero),
 *         response queue 23:22, port code 18:16, frame type 15:0, other bits zero
 *   0x10d pad drive strength, low byte: high-speed code 6:4, low-speed code 2:0,
 *         spare 7 and 3
 *   Every other word reads zero and ignores writes.
 *
 * Only word-sized transfers are decoded; narrower ones are dropped without an error,
 * so software must use whole-word accesses. A write lands at the end of its data phase.
 * Read data is registered at the read's address phase; a write to the same word still
 * in its data phase is merged in, so a read straight after a write sees the new value.
 * Address bits above 13 are not decoded, so the bank repeats through the space.
 *
 * Assumes hclk is the switch core clock, hresetn the device reset, and the strap pin
 * stable around the release of reset. The engine reset output is a one-cycle pulse; the
 * engine must act on it within that cycle.
 */
// Local design decision: the AHB-Lite slave port.
// Notes on behaviour
// - Clock out driven only when enabled; bit0 rate
// - In-band enable resets from port 6 strap
// - Match bit enables destination address check
// - Reset bit pulses engine reset, self-clears
// - Bits 23:22 select response priority queue
// - Bits 18:16 select in-band port
// - Bits 15:0 hold writable EtherType value
// - Bits 6:4 give high-speed drive code
// - Bits 2:0 give low-speed drive code
`timescale 1ns/10ps
`include "global_io_params.svh"

module global_io_control_regs (
    input wire logic hclk, // Core clock, 40 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic hready, // Bus ready in
    input wire global_io_pkg::word_type hwdata, // Write data
    output global_io_pkg::word_type hrdata, // Read data, registered
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    input wire logic port6_rx_valid_strap_pin, // Strap level for in-band enable
    output logic ref_clock_out_enable, // Drive the reference clock pin
    output logic ref_clock_out_fast, // 1 selects 125 MHz, 0 selects 25 MHz
    output logic in_band_access_enable, // In-band management enabled
    output logic in_band_access_match_enable, // Check destination address
    output logic in_band_access_reset, // One-cycle engine reset pulse
    output logic [1:0] in_band_access_queue, // Response priority queue
    output logic [2:0] in_band_access_port, // Port code, 110/111 reserved
    output logic [15:0] in_band_access_ethertype, // Frame type value
    output global_io_pkg::code3_type high_speed_drive, // Fast pad drive code
    output global_io_pkg::code3_type low_speed_drive // Slow pad drive code
);
    import global_io_pkg::*;

    // Reset images as constants, so that single fields can be sliced from them
    localparam logic [7:0] clk_reset_byte = `CLKCTL_RESET;
    localparam word_type iba_reset_word = `IBA_RESET;
    localparam logic [7:0] drive_reset_byte = `DRIVE_RESET;

    // Bus tracking and pulse state
    phase_type phase;
    logic [11:0] index;
    logic strap_done;
    logic reset_pulse;

    // Output clock control storage
    logic clk_rate;
    logic clk_enable;
    logic [2:0] clk_spare;

    // In-band control storage; the engine reset bit has no flop of its own
    logic iba_enable;
    logic iba_match;
    logic [1:0] iba_queue;
    logic [2:0] iba_port;
    logic [15:0] iba_type;

    // Pad drive strength storage
    code3_type drive_high;
    code3_type drive_low;
    logic [1:0] drive_spare;

    // Write strobes and register images as software reads them
    logic clk_write;
    logic iba_write;
    logic drive_write;
    logic [7:0] clk_image;
    word_type iba_image;
    logic [7:0] drive_image;

    // Word index decode used by both the write and read paths
    function automatic logic [11:0] word_index(input logic [31:0] addr);
        word_index = addr[13:2];
    endfunction : word_index

    // An address phase is taken only for active word-sized transfers
    function automatic logic addr_taken(input logic sel, input logic [1:0] trans, input logic [2:0] size);
        addr_taken = sel && trans[1] && size == 3'h2;
    endfunction : addr_taken

    // True while a write data phase targets the given word
    function automatic logic write_hit(input phase_type ph, input logic [11:0] idx,
            input logic [11:0] target);
        write_hit = ph == phase_write_type_s && idx == target;
    endfunction : write_hit

    // Software view of one word from the three images; every other word reads zero
    function automatic word_type read_view(input logic [11:0] idx, input logic [7:0] clk_img,
            input word_type iba_img, input logic [7:0] drive_img);
        case (idx)
            `CLKCTL_INDEX: begin
                read_view = {24'h000000, clk_img};
            end
            `IBACTL_INDEX: begin
                read_view = iba_img;
            end
            `DRIVE_INDEX: begin
                read_view = {24'h000000, drive_img};
            end
            default: begin
                read_view = 32'h0000_0000;
            end
        endcase
    endfunction : read_view

    // Address phase capture; narrower sizes fall back to idle and are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= phase_idle_type_s;
            index <= 12'h000;
        end else if (hready) begin
            if (addr_taken(hsel, htrans, hsize)) begin
                phase <= hwrite ? phase_write_type_s : phase_read_type_s;
                index <= word_index(haddr);
            end else begin
                phase <= phase_idle_type_s;
            end
        end
    end

    // Every word answers in one cycle, so the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Write strobes for the data phase of each register
    assign clk_write = write_hit(phase, index, `CLKCTL_INDEX);
    assign iba_write = write_hit(phase, index, `IBACTL_INDEX);
    assign drive_write = write_hit(phase, index, `DRIVE_INDEX);

    // Reference clock rate select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_rate <= clk_reset_byte[`CLKCTL_FREQ_BIT];
        end else if (clk_write) begin
            clk_rate <= hwdata[`CLKCTL_FREQ_BIT];
        end
    end

    // Reference clock pin enable; on from reset so the clock runs before software starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_enable <= clk_reset_byte[`CLKCTL_EN_BIT];
        end else if (clk_write) begin
            clk_enable <= hwdata[`CLKCTL_EN_BIT];
        end
    end

    // Spare bits 4:2 keep what software writes and drive nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_spare <= clk_reset_byte[4:2];
        end else if (clk_write) begin
            clk_spare <= hwdata[4:2];
        end
    end

    // Strap is caught at the first edge after release, not in the reset branch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    // In-band enable: strap value at the first edge after reset, software after that.
    // A write on that same edge wins, since software asked for it last.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iba_enable <= iba_reset_word[`IBA_EN_BIT];
        end else if (iba_write) begin
            iba_enable <= hwdata[`IBA_EN_BIT];
        end else if (!strap_done) begin
            iba_enable <= port6_rx_valid_strap_pin;
        end
    end

    // Destination address check enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iba_match <= iba_reset_word[`IBA_MATCH_BIT];
        end else if (iba_write) begin
            iba_match <= hwdata[`IBA_MATCH_BIT];
        end
    end

    // Response priority queue; best left at its reset value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iba_queue <= iba_reset_word[`IBA_PRIO_HI:`IBA_PRIO_LO];
        end else if (iba_write) begin
            iba_queue <= hwdata[`IBA_PRIO_HI:`IBA_PRIO_LO];
        end
    end

    // In-band port code; reserved codes are stored as written and left to the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iba_port <= iba_reset_word[`IBA_PORT_HI:`IBA_PORT_LO];
        end else if (iba_write) begin
            iba_port <= hwdata[`IBA_PORT_HI:`IBA_PORT_LO];
        end
    end

    // Frame type value that marks in-band frames
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iba_type <= iba_reset_word[`IBA_TYPE_HI:`IBA_TYPE_LO];
        end else if (iba_write) begin
            iba_type <= hwdata[`IBA_TYPE_HI:`IBA_TYPE_LO];
        end
    end

    // Self-clearing engine reset: a one-cycle pulse, the bit itself is never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_pulse <= 1'b0;
        end else begin
            reset_pulse <= iba_write && hwdata[`IBA_RST_BIT];
        end
    end

    // High-speed pad drive code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_high <= drive_reset_byte[`DRV_HIGH_HI:`DRV_HIGH_LO];
        end else if (drive_write) begin
            drive_high <= hwdata[`DRV_HIGH_HI:`DRV_HIGH_LO];
        end
    end

    // Low-speed pad drive code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_low <= drive_reset_byte[`DRV_LOW_HI:`DRV_LOW_LO];
        end else if (drive_write) begin
            drive_low <= hwdata[`DRV_LOW_HI:`DRV_LOW_LO];
        end
    end

    // Spare bits 7 and 3 are plain storage with no effect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_spare[1] <= drive_reset_byte[7];
            drive_spare[0] <= drive_reset_byte[3];
        end else if (drive_write) begin
            drive_spare[1] <= hwdata[7];
            drive_spare[0] <= hwdata[3];
        end
    end

    // Register images; reserved read-only bits and the engine reset bit read zero.
    // The enable shows the strap on the capture edge so an early read is not stale.
    assign clk_image = {3'b000, clk_spare, clk_enable, clk_rate};
    assign iba_image = {strap_done ? iba_enable : port6_rx_valid_strap_pin, iba_match, 6'h00, iba_queue,
        3'h0, iba_port, iba_type};
    assign drive_image = {drive_spare[1], drive_high, drive_spare[0], drive_low};

    // Read data registered at the address phase so it stands through the data phase.
    // A write to the same word still in its data phase is merged in; without it a
    // back-to-back write then read would return the old value.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && addr_taken(hsel, htrans, hsize) && !hwrite) begin
            if (write_hit(phase, index, word_index(haddr))) begin
                hrdata <= read_view(word_index(haddr), hwdata[7:0] & `CLKCTL_RW_MASK, hwdata & `IBA_RW_MASK,
                    hwdata[7:0]);
            end else begin
                hrdata <= read_view(word_index(haddr), clk_image, iba_image, drive_image);
            end
        end
    end

    // Reference clock pin controls
    assign ref_clock_out_enable = clk_enable;
    assign ref_clock_out_fast = clk_rate;

    // In-band management controls
    assign in_band_access_enable = iba_enable;
    assign in_band_access_match_enable = iba_match;
    assign in_band_access_reset = reset_pulse;
    assign in_band_access_queue = iba_queue;
    assign in_band_access_port = iba_port;
    assign in_band_access_ethertype = iba_type;

    // Pad drive codes
    assign high_speed_drive = drive_high;
    assign low_speed_drive = drive_low;
endmodule : global_io_control_regs

// ===== sim/global_io_checker_properties.sv
/* Checker of the global I/O registers: bus writes reaching the field outputs.
   Assumes a zero-wait AHB-Lite slave and word writes. */
`timescale 1ns/10ps
module global_io_checker (
    input wire logic hclk, hresetn, hsel, hwrite, hready,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire global_io_pkg::word_type hwdata,
    input wire logic ref_clock_out_enable, ref_clock_out_fast, in_band_access_enable,
    input wire logic in_band_access_match_enable, in_band_access_reset,
    input wire logic [1:0] in_band_access_queue,
    input wire logic [2:0] in_band_access_port,
    input wire logic [15:0] in_band_access_ethertype,
    input wire global_io_pkg::code3_type high_speed_drive, low_speed_drive,
    input wire logic port6_rx_valid_strap_pin
);
    logic wv;
    logic up;
    logic [13:0] wa;
    logic [31:0] pw;
    // Address phase is remembered, since its data comes a cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv <= 1'b0;
            wa <= 14'h0;
            pw <= 32'h0;
            up <= 1'b0;
        end else begin
            up <= 1'b1;
            wv <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
            wa <= haddr[13:0];
            pw <= hwdata;
        end
    end
    wire wc = wv && wa == 14'h40c;
    wire wi = wv && wa == 14'h410;
    wire wd = wv && wa == 14'h434;
    wire rq = wi && hwdata[29];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    clk_out_a: assert property (wc |=> {ref_clock_out_enable, ref_clock_out_fast} == pw[1:0])
        else $error("clock control not applied");
    iba_enable_a: assert property (wi |=> in_band_access_enable == pw[31])
        else $error("in-band enable not applied");
    strap_load_a: assert property (!up |=> in_band_access_enable == $past(port6_rx_valid_strap_pin))
        else $error("strap not loaded after reset");
    match_en_a: assert property (wi |=> in_band_access_match_enable == pw[30])
        else $error("match enable not applied");
    reset_pulse_a: assert property (rq |=> in_band_access_reset ##1 !in_band_access_reset)
        else $error("engine reset not one cycle");
    pulse_cause_a: assert property (in_band_access_reset |-> $past(rq))
        else $error("engine reset without write");
    queue_sel_a: assert property (wi |=> in_band_access_queue == pw[23:22])
        else $error("queue field not applied");
    port_sel_a: assert property (wi |=> in_band_access_port == pw[18:16])
        else $error("port field not applied");
    ether_type_a: assert property (wi |=> in_band_access_ethertype == pw[15:0])
        else $error("type field not applied");
    drive_code_a: assert property (wd |=> {high_speed_drive, low_speed_drive} == {pw[6:4], pw[2:0]})
        else $error("drive codes not applied");
    cover property (rq);
    cover property (wc);
    cover property (wd);
endmodule : global_io_checker
bind global_io_control_regs global_io_checker global_io_checker_inst (.*);

// ===== sim/tb_global_io_control_regs.sv
/* Testbench of the global I/O registers: reset values, corner and random writes, read-back,
   field outputs, unmapped place, strap reset. Assumes the checker is bound to the design. */
`timescale 1ns/10ps
module tb_global_io_control_regs;
    import global_io_pkg::*;
    logic hclk = 0, hresetn = 0, hwrite = 0, strap = 1, ce, cf, ie, im, ir, hreadyout, hresp;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0, iq;
    logic [2:0] ip;
    logic [15:0] it;
    code3_type hd, ld;
    word_type hwdata = 0, hrdata, m;
    int bad_count = 0, total_checks = 0, cyc = 0;
    localparam logic [31:0] reg_addr [3] = '{32'h40c, 32'h410, 32'h434};
    always #12.5 hclk = ~hclk;
    global_io_control_regs global_io_control_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port6_rx_valid_strap_pin(strap),
        .ref_clock_out_enable(ce), .ref_clock_out_fast(cf), .in_band_access_enable(ie),
        .in_band_access_match_enable(im), .in_band_access_reset(ir), .in_band_access_queue(iq),
        .in_band_access_port(ip), .in_band_access_ethertype(it), .high_speed_drive(hd), .low_speed_drive(ld));
    // Readable bits of each register; the rest read zero
    function automatic word_type rd_mask(int k);
        return k == 0 ? 32'h1f : k == 1 ? 32'hc0c7ffff : 32'hff;
    endfunction : rd_mask
    task automatic chk(input string n, input word_type e, s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One single transfer; the address is held until ready is seen
    task automatic xfer(input logic [31:0] a, input logic w, input word_type d);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        m = hrdata;
    endtask : xfer
    // Outputs are sampled mid-cycle, where they are settled
    task automatic fields(input word_type c, i, d, input logic p);
        @(negedge hclk);
        chk("clk_out", c & 32'h3, {30'h0, ce, cf});
        chk("iba_ctl", i & 32'hc0c7ffff, {ie, im, 6'h0, iq, 3'h0, ip, it});
        chk("eng_reset", {31'h0, p}, {31'h0, ir});
        chk("drive", d & 32'h77, {25'h0, hd, 1'b0, ld});
        chk("bus_answer", 32'h2, {30'h0, hreadyout, hresp}); // Zero wait, OKAY answer
    endtask : fields
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // Cuts a hang short
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        word_type s [3], d;
        int k;
        void'($urandom(32'hc696));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        s = '{32'h2, 32'h804540fe, 32'h62};
        for (k = 0; k < 3; k++) begin
            xfer(reg_addr[k], 1'b0, 32'h0);
            chk("reset_val", s[k], m);
        end
        fields(s[0], s[1], s[2], 1'b0);
        $display("test reset values done");
        // All ones, all zeros, then random words to each register
        for (int i = 0; i < 30; i++) begin
            k = i % 3;
            d = i < 3 ? 32'hffffffff : i < 6 ? 32'h0 : $urandom;
            xfer(reg_addr[k], 1'b1, d);
            s[k] = d & rd_mask(k);
            fields(s[0], s[1], s[2], k == 1 && d[29]);
            xfer(reg_addr[k], 1'b0, 32'h0);
            chk("readback", s[k], m);
        end
        $display("test write read done");
        xfer(32'h500, 1'b1, 32'hffffffff);
        xfer(32'h500, 1'b0, 32'h0);
        chk("unmapped", 32'h0, m);
        $display("test unmapped done");
        @(posedge hclk);
        hresetn <= 1'b0;
        strap <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(reg_addr[1], 1'b0, 32'h0);
        chk("strap_low", 32'h004540fe, m);
        $display("test strap done");
        finish_test();
    end
endmodule : tb_global_io_control_regs
